// *** tb/scp_properties.sv ***
// Concurrent checks on the configuration pin link and on the device status outputs.
// Assumes one mclk domain with srst shared by both ends; instantiated beside the interface.
`timescale 1ns/10ps
`include "scp_regs.svh"

module scp_properties (
	// Clock and reset
	input logic                  mclk,
	input logic                  srst,
	// Pins seen on the link
	input logic                  sys_reset_n,
	input logic                  word_align_on,
	input logic                  double_rate_on,
	input logic                  tx_all_outputs_on,
	input logic [`SCP_LANES-1:0] transceiver_off,
	input logic                  loopback_on,
	input logic                  loopback_output_drive,
	input logic                  sync_drop,
	input logic                  tx_equalization_on,
	// Device status
	input logic                  dev_run,
	input logic                  dev_in_reset,
	input logic [`SCP_CFG_W-1:0] cfg_applied,
	input logic [`SCP_LANES-1:0] lane_bit_locked,
	input logic [`SCP_LANES-1:0] lane_synced,
	input logic [`SCP_LANES-1:0] lane_err_burst,
	input logic [`SCP_LANES-1:0] tx_out_en
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	chk_cfg_in_reset: assert property ($changed({word_align_on, double_rate_on}) |-> !sys_reset_n)
		else $error("reset-class pin moved outside a reset pulse");
	chk_pulse_width: assert property ($fell(sys_reset_n) |-> (!sys_reset_n)[*8] ##[1:4] sys_reset_n)
		else $error("system reset pulse has the wrong width");
	chk_sync_delay: assert property ($fell(sys_reset_n) && !dev_in_reset |=> !dev_in_reset ##[1:2] dev_in_reset)
		else $error("system reset not taken through the synchroniser");
	chk_cfg_frozen: assert property (dev_run |-> $stable(cfg_applied))
		else $error("applied configuration moved while running");
	chk_startup_gap: assert property (dev_in_reset ##1 !dev_in_reset |-> (!dev_run)[*8])
		else $error("run reached without the startup steps");
	chk_tx_enable: assert property ($stable({tx_all_outputs_on, transceiver_off, loopback_on,
		loopback_output_drive})[*5] |-> tx_out_en ==
		({`SCP_LANES{tx_all_outputs_on & (!loopback_on | loopback_output_drive)}} & ~transceiver_off))
		else $error("transmit enables do not follow the pins");
	chk_loop_restart: assert property (dev_run && $changed(loopback_on) |-> ##[2:6] lane_bit_locked == 4'h0)
		else $error("loopback change did not restart the lanes");
	chk_drop_resync: assert property (dev_run && $changed(sync_drop) && lane_synced == 4'hF
		|-> ##[2:6] (lane_synced == 4'h0 && lane_bit_locked == 4'hF))
		else $error("sync drop did not resync with phase kept");
	chk_eq_burst: assert property (dev_run && $changed(tx_equalization_on) |-> ##[2:6] lane_err_burst == 4'hF)
		else $error("equalization change gave no error window");
endmodule : scp_properties

// *** tb/tb_serdes_config_pin_handling.sv ***
// Self-checking bench: APB master on the controller, both ends joined by the pin interface.
// Assumes a 10 MHz mclk; PLL count shortened so the startup checks stay brief.
`timescale 1ns/10ps
`include "scp_regs.svh"

module tb_serdes_config_pin_handling;
	localparam int PLL_B = 64;
	localparam int EQ_B  = 16;
	logic                  mclk, srst, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic                  dev_run, dev_in_reset, loop_active;
	logic [`SCP_CFG_W-1:0] cfg_applied;
	logic [3:0]            lane_bit_locked, lane_synced, lane_err_burst, lane_redundant, tx_out_en;
	int                    bad_count;
	int                    cmp_count;

	scp_cfg_if scp_cfg_if_inst ();
	scp_ctl #(.RST_CYC(10), .SETTLE_CYC(20)) scp_ctl_inst (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(scp_cfg_if_inst.ctl));
	scp_dev #(.PLL_BITS(PLL_B), .EQ_BURST(EQ_B)) scp_dev_inst (.mclk(mclk), .srst(srst),
		.pins(scp_cfg_if_inst.dev), .dev_run(dev_run), .dev_in_reset(dev_in_reset),
		.cfg_applied(cfg_applied), .lane_bit_locked(lane_bit_locked), .lane_synced(lane_synced),
		.lane_err_burst(lane_err_burst), .lane_redundant(lane_redundant), .tx_out_en(tx_out_en),
		.loop_active(loop_active));
	scp_properties scp_properties_inst (.mclk(mclk), .srst(srst),
		.sys_reset_n(scp_cfg_if_inst.sys_reset_n), .word_align_on(scp_cfg_if_inst.word_align_on),
		.double_rate_on(scp_cfg_if_inst.double_rate_on), .tx_all_outputs_on(scp_cfg_if_inst.tx_all_outputs_on),
		.transceiver_off(scp_cfg_if_inst.transceiver_off), .loopback_on(scp_cfg_if_inst.loopback_on),
		.loopback_output_drive(scp_cfg_if_inst.loopback_output_drive), .sync_drop(scp_cfg_if_inst.sync_drop),
		.tx_equalization_on(scp_cfg_if_inst.tx_equalization_on), .dev_run(dev_run),
		.dev_in_reset(dev_in_reset), .cfg_applied(cfg_applied), .lane_bit_locked(lane_bit_locked),
		.lane_synced(lane_synced), .lane_err_burst(lane_err_burst), .tx_out_en(tx_out_en));

	initial mclk = 1'b0;
	always #50 mclk = ~mclk;

	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Holds the request until pready is sampled high; one idle edge after so psel is never driven twice
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		chk(32'(pready), 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic wait_sync(input int lim);
		int n;
		n = 0;
		while (lane_synced !== 4'hF && n < lim) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(lane_synced), 32'hF);
	endtask : wait_sync

	// Counts edges from leaving reset to run; the sequence must take its expected length
	task automatic startup(input int exp);
		int n;
		n = 0;
		while (dev_in_reset !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (dev_in_reset !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (dev_run !== 1'b1 && n < exp + 50) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n >= exp - 1 && n <= exp + 3), 32'h1);
		// Lanes move to sync on the edge after run is first seen
		@(posedge mclk);
	endtask : startup

	task automatic t_startup;
		startup(PLL_B + 250 + 300);
		chk(32'(cfg_applied), 32'h0000_0010);
		chk(32'(lane_synced), 32'h0000_000F);
		chk(32'(tx_out_en), 32'h0000_000F);
	endtask : t_startup

	task automatic t_regs;
		apb(1'b0, `SCP_A_CTRL, 32'h0);
		chk(rd, 32'h0000_0800);
		apb(1'b0, `SCP_A_CFG, 32'h0);
		chk(rd, 32'h0000_0010);
		apb(1'b0, `SCP_A_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk(32'(er), 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SCP_A_CTRL, 32'h0);
		chk(rd, 32'h0000_0800);
	endtask : t_regs

	task automatic t_cfg;
		apb(1'b1, `SCP_A_CFG, 32'h0000_0410);
		repeat (20) @(posedge mclk);
		chk(32'(cfg_applied), 32'h0000_0010);
		chk(32'(scp_cfg_if_inst.word_align_on), 32'h0);
		apb(1'b0, `SCP_A_STAT, 32'h0);
		chk(rd & 32'h2, 32'h2);
		apb(1'b1, `SCP_A_CMD, 32'h0);
		apb(1'b0, `SCP_A_STAT, 32'h0);
		chk(rd & 32'h1, 32'h0);
		apb(1'b1, `SCP_A_CMD, 32'h1);
		apb(1'b0, `SCP_A_STAT, 32'h0);
		chk(rd & 32'h1, 32'h1);
		startup(PLL_B + 250 + 460 + 160);
		chk(32'(cfg_applied), 32'h0000_0410);
		chk(32'(lane_synced), 32'h0000_000F);
	endtask : t_cfg

	task automatic t_drop;
		apb(1'b1, `SCP_A_CTRL, 32'h0000_0900);
		repeat (6) @(posedge mclk);
		chk(32'(lane_synced), 32'h0);
		chk(32'(lane_bit_locked), 32'h0000_000F);
		wait_sync(400);
	endtask : t_drop

	task automatic t_lane;
		apb(1'b1, `SCP_A_CTRL, 32'h0000_0901);
		repeat (6) @(posedge mclk);
		chk(32'(lane_bit_locked), 32'h0000_000E);
		wait_sync(600);
		chk(32'(lane_redundant), 32'h0000_0001);
	endtask : t_lane

	task automatic t_loop;
		apb(1'b1, `SCP_A_CTRL, 32'h0000_1901);
		repeat (6) @(posedge mclk);
		chk(32'(tx_out_en), 32'h0);
		chk(32'(lane_bit_locked), 32'h0);
		chk(32'(loop_active), 32'h1);
		wait_sync(600);
		apb(1'b1, `SCP_A_CTRL, 32'h0000_3901);
		repeat (6) @(posedge mclk);
		chk(32'(tx_out_en), 32'h0000_000F);
		chk(32'(lane_synced), 32'h0000_000F);
	endtask : t_loop

	task automatic t_eq;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `SCP_A_CTRL, (i == 0) ? 32'h0000_3B01 : 32'h0000_3F01);
			repeat (6) @(posedge mclk);
			chk(32'(lane_err_burst), 32'h0000_000F);
			repeat (EQ_B + 4) @(posedge mclk);
			chk(32'(lane_err_burst), 32'h0);
			chk(32'(lane_synced), 32'h0000_000F);
		end
	endtask : t_eq

	task automatic t_off;
		apb(1'b1, `SCP_A_CTRL, 32'h0000_3F41);
		apb(1'b0, `SCP_A_STAT, 32'h0);
		chk(rd & 32'h4, 32'h4);
		repeat (6) @(posedge mclk);
		chk(32'(tx_out_en), 32'h0000_000B);
		chk(32'(lane_synced), 32'h0000_000B);
		apb(1'b1, `SCP_A_CTRL, 32'h0000_3741);
		repeat (6) @(posedge mclk);
		chk(32'(tx_out_en), 32'h0);
	endtask : t_off

	initial begin
		bad_count = 0;
		cmp_count = 0;
		srst      = 1'b1;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		t_startup();
		t_regs();
		t_cfg();
		t_drop();
		t_lane();
		t_loop();
		t_eq();
		t_off();
		final_report();
	end

	// Whole run is a few thousand cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		final_report();
	end
endmodule : tb_serdes_config_pin_handling

// *** verilog/scp_cfg_if.sv ***
// Configuration and control pins between the system controller and the serdes.
// All signals are driven by the controller and are asynchronous to the device.
`timescale 1ns/10ps
`include "scp_regs.svh"

interface scp_cfg_if;
	logic [`SCP_LANES-1:0] redundant_link_select;
	logic [`SCP_LANES-1:0] transceiver_off;
	logic                  sync_drop;
	logic                  tx_equalization_on;
	logic                  rx_equalization_on;
	logic                  tx_all_outputs_on;
	logic                  loopback_on;
	logic                  loopback_output_drive;
	logic                  tx_refclk_a_select;
	logic                  rx_refclk_a_select;
	logic                  ten_bit_interface_on;
	logic                  half_speed_on;
	logic                  double_rate_on;
	logic                  byte_align_mode;
	logic                  idle_add_drop_on;
	logic                  repeater_on;
	logic                  link_mux_mode;
	logic                  recovered_clock_on;
	logic                  word_align_on;
	logic                  sys_reset_n;

	modport dev (
		input redundant_link_select, transceiver_off, sync_drop, tx_equalization_on,
		rx_equalization_on, tx_all_outputs_on, loopback_on, loopback_output_drive,
		tx_refclk_a_select, rx_refclk_a_select, ten_bit_interface_on, half_speed_on,
		double_rate_on, byte_align_mode, idle_add_drop_on, repeater_on, link_mux_mode,
		recovered_clock_on, word_align_on, sys_reset_n
	);

	modport ctl (
		output redundant_link_select, transceiver_off, sync_drop, tx_equalization_on,
		rx_equalization_on, tx_all_outputs_on, loopback_on, loopback_output_drive,
		tx_refclk_a_select, rx_refclk_a_select, ten_bit_interface_on, half_speed_on,
		double_rate_on, byte_align_mode, idle_add_drop_on, repeater_on, link_mux_mode,
		recovered_clock_on, word_align_on, sys_reset_n
	);
endinterface : scp_cfg_if

// *** verilog/scp_ctl.sv ***
// Controller end: an APB slave whose registers drive the configuration pins.
// Reset-class settings reach the pins only inside a reset pulse, so a written change waits in the shadow for a reset command.
`timescale 1ns/10ps
`include "scp_regs.svh"

module scp_ctl #(
	parameter int RST_CYC    = `SCP_RST_HOLD_CYC,
	parameter int SETTLE_CYC = 1000
) (
	// Clock and reset
	input  wire logic                               mclk,
	input  wire logic                               srst,
	// APB slave
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [7:0]                         paddr,
	input  wire logic [31:0]                        pwdata,
	output      logic [31:0]                        prdata,
	output      logic                               pready,
	output      logic                               pslverr,
	// Configuration pins
	scp_cfg_if.ctl                                  pins
);

	localparam logic [15:0] RST_N    = 16'(RST_CYC);
	localparam logic [15:0] SETTLE_N = 16'(SETTLE_CYC);

	scp_pkg::scp_ctl_state_t q;
	scp_pkg::scp_ctl_state_t n;
	logic                    acc;

	assign acc    = psel && penable;
	assign pready = acc;

	always_comb begin
		n = q;
		if (q.settle != 16'h0000)
			n.settle = q.settle - 16'h0001;

		// Read data and error are prepared in the setup cycle so both come from flops
		if (psel && !penable) begin
			n.pslverr = 1'b0;
			case (paddr)
				`SCP_A_CTRL: n.prdata = {18'h0, q.ctrl};
				`SCP_A_CFG:  n.prdata = {21'h0, q.shadow};
				`SCP_A_CMD:  n.prdata = 32'h00000000;
				`SCP_A_STAT: n.prdata = {29'h0, q.settle != 16'h0000,
					q.shadow != q.cfg_pin, q.st == scp_pkg::C_HOLD};
				default: begin
					n.prdata = 32'h00000000;
					n.pslverr = 1'b1;
				end
			endcase
		end

		// Pulse timing comes first so a reset command written inside a pulse restarts its count
		case (q.st)
			scp_pkg::C_HOLD: begin
				n.cnt = q.cnt + 16'h0001;
				// Shadow moves to the pins two cycles after reset goes low, never outside a pulse
				if (q.cnt == 16'h0001)
					n.cfg_pin = q.shadow;
				if (q.cnt >= RST_N - 16'h0001)
					n.st = scp_pkg::C_IDLE;
			end
			scp_pkg::C_IDLE: n.cnt = 16'h0000;
			default: n.st = scp_pkg::C_HOLD;
		endcase

		if (acc && pwrite && !q.pslverr) begin
			case (paddr)
				`SCP_A_CTRL: begin
					// Live pins still upset the links; software waits out the settle flag
					if (pwdata[`SCP_CTRL_W-1:0] != q.ctrl)
						n.settle = SETTLE_N;
					n.ctrl = pwdata[`SCP_CTRL_W-1:0];
				end
				`SCP_A_CFG: n.shadow = pwdata[`SCP_CFG_W-1:0];
				`SCP_A_CMD: begin
					if (pwdata[`SCP_CMD_RESET]) begin
						n.st = scp_pkg::C_HOLD;
						n.cnt = 16'h0000;
					end
				end
				default: begin
					n.ctrl = q.ctrl;
				end
			endcase
		end

		n.rst_n = (n.st != scp_pkg::C_HOLD);
	end

	// Power-up starts inside a reset pulse with the default settings on the pins
	always_ff @(posedge mclk) begin
		if (srst) begin
			q         <= '0;
			q.ctrl    <= `SCP_CTRL_RST;
			q.shadow  <= `SCP_CFG_RST;
			q.cfg_pin <= `SCP_CFG_RST;
		end else begin
			q <= n;
		end
	end

	assign prdata  = q.prdata;
	assign pslverr = q.pslverr && acc;

	assign pins.redundant_link_select = q.ctrl[`SCP_P_LSEL +: `SCP_LANES];
	assign pins.transceiver_off       = q.ctrl[`SCP_P_OFF +: `SCP_LANES];
	assign pins.sync_drop             = q.ctrl[`SCP_P_DROP];
	assign pins.tx_equalization_on    = q.ctrl[`SCP_P_TXEQ];
	assign pins.rx_equalization_on    = q.ctrl[`SCP_P_RXEQ];
	assign pins.tx_all_outputs_on     = q.ctrl[`SCP_P_TXALL];
	assign pins.loopback_on           = q.ctrl[`SCP_P_LOOP];
	assign pins.loopback_output_drive = q.ctrl[`SCP_P_LOOPOUT];
	assign pins.tx_refclk_a_select    = q.cfg_pin[`SCP_C_TXREF];
	assign pins.rx_refclk_a_select    = q.cfg_pin[`SCP_C_RXREF];
	assign pins.ten_bit_interface_on  = q.cfg_pin[`SCP_C_TENBIT];
	assign pins.half_speed_on         = q.cfg_pin[`SCP_C_HALF];
	assign pins.double_rate_on        = q.cfg_pin[`SCP_C_DDR];
	assign pins.byte_align_mode       = q.cfg_pin[`SCP_C_BYTEM];
	assign pins.idle_add_drop_on      = q.cfg_pin[`SCP_C_IDLE];
	assign pins.repeater_on           = q.cfg_pin[`SCP_C_REP];
	assign pins.link_mux_mode         = q.cfg_pin[`SCP_C_MUX];
	assign pins.recovered_clock_on    = q.cfg_pin[`SCP_C_RCLK];
	assign pins.word_align_on         = q.cfg_pin[`SCP_C_WORD];
	assign pins.sys_reset_n           = q.rst_n;

endmodule : scp_ctl

// *** verilog/scp_dev.sv ***
// Device end: synchronises the configuration pins, runs the startup sequence and
// tracks per-lane alignment. Assumes the pins may change at any time relative to mclk.
`timescale 1ns/10ps
`include "scp_regs.svh"

module scp_dev #(
	parameter int PLL_BITS    = `SCP_PLL_BITS,
	parameter int BIT_CYC     = 1,
	parameter int PHASE_BITS  = 64,
	parameter int BYTE_BITS   = 40,
	parameter int EQ_BURST    = 16
) (
	// Clock and power-on reset
	input  wire logic                               mclk,
	input  wire logic                               srst,
	// Configuration pins
	scp_cfg_if.dev                                  pins,
	// Device status
	output      logic                               dev_run,
	output      logic                               dev_in_reset,
	output      logic [`SCP_CFG_W-1:0]              cfg_applied,
	output      logic [`SCP_LANES-1:0]              lane_bit_locked,
	output      logic [`SCP_LANES-1:0]              lane_synced,
	output      logic [`SCP_LANES-1:0]              lane_err_burst,
	output      logic [`SCP_LANES-1:0]              lane_redundant,
	output      logic [`SCP_LANES-1:0]              tx_out_en,
	output      logic                               loop_active
);

	function automatic logic [23:0] bits_to_cyc(input int bits);
		bits_to_cyc = 24'(bits * BIT_CYC);
	endfunction : bits_to_cyc

	localparam logic [23:0] PLL_N    = 24'(PLL_BITS * BIT_CYC + `SCP_PLL_SETTLE_CYC);
	localparam logic [23:0] RXI_N    = 24'(`SCP_RXINIT_BITS * BIT_CYC);
	localparam logic [23:0] RXI_W_N  = 24'(`SCP_RXINIT_W_BITS * BIT_CYC);
	localparam logic [11:0] L_WORD_N = 12'(`SCP_WORD_BITS * BIT_CYC);
	localparam logic [11:0] PHASE_N  = 12'(PHASE_BITS * BIT_CYC);
	localparam logic [11:0] BYTE_N   = 12'(BYTE_BITS * BIT_CYC);
	localparam logic [7:0]  BURST_N  = 8'(EQ_BURST);

	scp_pkg::scp_dev_state_t q;
	scp_pkg::scp_dev_state_t n;
	logic [`SCP_PIN_W-1:0]   pin_vec;
	logic [`SCP_PIN_W-1:0]   chg;
	logic                    word_on;
	logic                    lane_restart;
	logic                    lane_realign;

	assign pin_vec = {pins.sys_reset_n, pins.word_align_on, pins.recovered_clock_on, pins.link_mux_mode,
		pins.repeater_on, pins.idle_add_drop_on, pins.byte_align_mode, pins.double_rate_on,
		pins.half_speed_on, pins.ten_bit_interface_on, pins.rx_refclk_a_select, pins.tx_refclk_a_select,
		pins.loopback_output_drive, pins.loopback_on, pins.tx_all_outputs_on, pins.rx_equalization_on,
		pins.tx_equalization_on, pins.sync_drop, pins.transceiver_off, pins.redundant_link_select};

	always_comb begin
		n = q;
		// Stage one feeds stage two only; change detection compares two and three
		n.s1 = pin_vec;
		n.s2 = q.s1;
		n.s3 = q.s2;
		chg = q.s2 ^ q.s3;
		word_on = q.cfg[`SCP_C_WORD];
		lane_restart = 1'b0;
		lane_realign = 1'b0;
		n.cnt = q.cnt + 24'h000001;

		if (!q.s2[`SCP_P_RSTN]) begin
			// Reset-class pins are latched only here; later changes wait for the next reset
			n.cfg = q.s2[`SCP_P_CFG +: `SCP_CFG_W];
			n.st = scp_pkg::D_RESET;
			n.cnt = 24'h000000;
			n.lane = {`SCP_LANES{scp_pkg::L_IDLE}};
			n.lcnt = '0;
			n.burst = '0;
		end else begin
			case (q.st)
				scp_pkg::D_RESET: begin
					n.st = scp_pkg::D_PLL;
					n.cnt = 24'h000000;
				end
				scp_pkg::D_PLL: begin
					if (q.cnt >= PLL_N - 24'h000001) begin
						n.st = scp_pkg::D_RXINIT;
						n.cnt = 24'h000000;
					end
				end
				scp_pkg::D_RXINIT: begin
					if (q.cnt >= (word_on ? RXI_W_N : RXI_N) - 24'h000001) begin
						n.st = word_on ? scp_pkg::D_WORD : scp_pkg::D_RUN;
						n.cnt = 24'h000000;
					end
				end
				scp_pkg::D_WORD: begin
					if (q.cnt >= bits_to_cyc(`SCP_WORD_BITS) - 24'h000001) begin
						n.st = scp_pkg::D_RUN;
						n.cnt = 24'h000000;
					end
				end
				scp_pkg::D_RUN: begin
					n.cnt = q.cnt;
				end
				default: begin
					n.st = scp_pkg::D_RESET;
				end
			endcase

			// Equalization may change live; flag a short error window on every lane
			for (int i = 0; i < `SCP_LANES; i++) begin
				if (chg[`SCP_P_TXEQ] || chg[`SCP_P_RXEQ])
					n.burst[i] = BURST_N;
				else if (q.burst[i] != 8'h00)
					n.burst[i] = q.burst[i] - 8'h01;
			end

			for (int i = 0; i < `SCP_LANES; i++) begin
				lane_restart = chg[`SCP_P_LSEL + i] || chg[`SCP_P_OFF + i] || chg[`SCP_P_LOOP];
				lane_realign = chg[`SCP_P_DROP];
				n.lcnt[i] = q.lcnt[i] + 12'h001;
				if (q.st != scp_pkg::D_RUN) begin
					n.lane[i] = scp_pkg::L_IDLE;
					n.lcnt[i] = 12'h000;
				end else if (q.s2[`SCP_P_OFF + i]) begin
					n.lane[i] = scp_pkg::L_IDLE;
					n.lcnt[i] = 12'h000;
				end else if (q.lane[i] == scp_pkg::L_IDLE) begin
					// Startup already aligned a lane that was on at reset; a lane turned on later is new
					n.lane[i] = lane_restart ? scp_pkg::L_PHASE : scp_pkg::L_SYNC;
					n.lcnt[i] = 12'h000;
				end else if (lane_restart) begin
					n.lane[i] = scp_pkg::L_PHASE;
					n.lcnt[i] = 12'h000;
				end else if (lane_realign && q.lane[i] != scp_pkg::L_PHASE) begin
					n.lane[i] = scp_pkg::L_BYTE;
					n.lcnt[i] = 12'h000;
				end else begin
					case (q.lane[i])
						scp_pkg::L_PHASE: begin
							if (q.lcnt[i] >= PHASE_N - 12'h001) begin
								n.lane[i] = scp_pkg::L_BYTE;
								n.lcnt[i] = 12'h000;
							end
						end
						scp_pkg::L_BYTE: begin
							if (q.lcnt[i] >= BYTE_N - 12'h001) begin
								n.lane[i] = word_on ? scp_pkg::L_WORD : scp_pkg::L_SYNC;
								n.lcnt[i] = 12'h000;
							end
						end
						scp_pkg::L_WORD: begin
							if (q.lcnt[i] >= L_WORD_N - 12'h001) begin
								n.lane[i] = scp_pkg::L_SYNC;
								n.lcnt[i] = 12'h000;
							end
						end
						scp_pkg::L_SYNC: begin
							n.lcnt[i] = q.lcnt[i];
						end
						default: begin
							n.lane[i] = scp_pkg::L_IDLE;
						end
					endcase
				end
			end
		end

		// Output drive follows its synchronised pins one cycle on, in reset as in run, with no lane resync
		for (int i = 0; i < `SCP_LANES; i++)
			n.tx_en[i] = q.s2[`SCP_P_TXALL] && !q.s2[`SCP_P_OFF + i] &&
				(!q.s2[`SCP_P_LOOP] || q.s2[`SCP_P_LOOPOUT]);
	end

	always_ff @(posedge mclk) begin
		if (srst)
			q <= '0;
		else
			q <= n;
	end

	always_comb begin
		dev_run      = (q.st == scp_pkg::D_RUN);
		dev_in_reset = (q.st == scp_pkg::D_RESET);
		cfg_applied  = q.cfg;
		tx_out_en    = q.tx_en;
		loop_active  = q.s3[`SCP_P_LOOP];
		lane_redundant = q.s3[`SCP_P_LSEL +: `SCP_LANES];
		for (int i = 0; i < `SCP_LANES; i++) begin
			lane_bit_locked[i] = (q.lane[i] == scp_pkg::L_BYTE) || (q.lane[i] == scp_pkg::L_WORD) ||
				(q.lane[i] == scp_pkg::L_SYNC);
			lane_synced[i]     = (q.lane[i] == scp_pkg::L_SYNC);
			lane_err_burst[i]  = (q.burst[i] != 8'h00);
		end
	end

endmodule : scp_dev

// *** verilog/scp_pkg.sv ***
// Types shared by both ends of the configuration pin link.
// Assumes scp_regs.svh is on the include path.
`include "scp_regs.svh"

package scp_pkg;

	typedef enum logic [2:0] {
		D_RESET  = 3'h0,
		D_PLL    = 3'h1,
		D_RXINIT = 3'h2,
		D_WORD   = 3'h3,
		D_RUN    = 3'h4
	} scp_dev_st_t;

	typedef enum logic [2:0] {
		L_IDLE  = 3'h0,
		L_PHASE = 3'h1,
		L_BYTE  = 3'h2,
		L_WORD  = 3'h3,
		L_SYNC  = 3'h4
	} scp_lane_st_t;

	typedef enum logic {
		C_HOLD = 1'b0,
		C_IDLE = 1'b1
	} scp_ctl_st_t;

	typedef struct packed {
		logic [`SCP_PIN_W-1:0]                  s1;
		logic [`SCP_PIN_W-1:0]                  s2;
		logic [`SCP_PIN_W-1:0]                  s3;
		logic [`SCP_CFG_W-1:0]                  cfg;
		scp_dev_st_t                            st;
		logic [23:0]                            cnt;
		scp_lane_st_t [`SCP_LANES-1:0]          lane;
		logic [`SCP_LANES-1:0][11:0]            lcnt;
		logic [`SCP_LANES-1:0][7:0]             burst;
		logic [`SCP_LANES-1:0]                  tx_en;
	} scp_dev_state_t;

	typedef struct packed {
		scp_ctl_st_t                            st;
		logic [15:0]                            cnt;
		logic                                   rst_n;
		logic [`SCP_CTRL_W-1:0]                 ctrl;
		logic [`SCP_CFG_W-1:0]                  shadow;
		logic [`SCP_CFG_W-1:0]                  cfg_pin;
		logic [15:0]                            settle;
		logic [31:0]                            prdata;
		logic                                   pslverr;
	} scp_ctl_state_t;

endpackage : scp_pkg

// *** verilog/scp_regs.svh ***
// Constants for the serdes configuration pin handling: pin positions, register map, reset values, timing.
// Assumes a 10 MHz mclk; included by the package and by both ends.
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Pin vector layout, low bits equal the control register layout
`define SCP_LANES       4
`define SCP_P_LSEL      0
`define SCP_P_OFF       4
`define SCP_P_DROP      8
`define SCP_P_TXEQ      9
`define SCP_P_RXEQ      10
`define SCP_P_TXALL     11
`define SCP_P_LOOP      12
`define SCP_P_LOOPOUT   13
`define SCP_P_CFG       14
`define SCP_P_RSTN      25
`define SCP_PIN_W       26

// Reset-class configuration field positions
`define SCP_CFG_W       11
`define SCP_C_TXREF     0
`define SCP_C_RXREF     1
`define SCP_C_TENBIT    2
`define SCP_C_HALF      3
`define SCP_C_DDR       4
`define SCP_C_BYTEM     5
`define SCP_C_IDLE      6
`define SCP_C_REP       7
`define SCP_C_MUX       8
`define SCP_C_RCLK      9
`define SCP_C_WORD      10

// Controller register map (byte addresses)
`define SCP_A_CTRL      8'h00
`define SCP_A_CFG       8'h04
`define SCP_A_CMD       8'h08
`define SCP_A_STAT      8'h0C
`define SCP_CTRL_W      14
`define SCP_CTRL_RST    14'h0800
`define SCP_CFG_RST     11'h010
`define SCP_CMD_RESET   0
`define SCP_S_RESET     0
`define SCP_S_PENDING   1
`define SCP_S_SETTLE    2

// Timing
`define SCP_CLK_NS          100
`define SCP_PLL_SETTLE_NS   25000
`define SCP_PLL_SETTLE_CYC  ((`SCP_PLL_SETTLE_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_PLL_BITS        20480
`define SCP_RXINIT_BITS     300
`define SCP_RXINIT_W_BITS   460
`define SCP_WORD_BITS       160
`define SCP_RST_HOLD_NS     1000
`define SCP_RST_HOLD_CYC    ((`SCP_RST_HOLD_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)

`endif
